// File: core/drum_status_pkg.sv
// constants shared by the drum controller status and error logic
// assumes a 10 MHz controller clock and one channel-facing port set
`default_nettype none
package drum_status_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int REPLY_MIN_RW_PS = 100000; // 0.1 us
	localparam int REPLY_MIN_WC_PS = 160000; // 0.16 us
	localparam int REPLY_DROP_PS = 40000; // 0.04 us
	localparam int CLK_PERIOD_PS = CLK_PERIOD_NS * 1000;
	// least times round up, never below one cycle
	localparam int REPLY_RW_CYC_I =
		(REPLY_MIN_RW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REPLY_WC_CYC_I =
		(REPLY_MIN_WC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REPLY_DROP_CYC_I = (REPLY_DROP_PS / CLK_PERIOD_PS < 1) ?
		1 : REPLY_DROP_PS / CLK_PERIOD_PS;
	localparam logic [3:0] REPLY_RW_CYC = 4'(REPLY_RW_CYC_I);
	localparam logic [3:0] REPLY_WC_CYC = 4'(REPLY_WC_CYC_I);
	localparam logic [3:0] REPLY_DROP_CYC = 4'(REPLY_DROP_CYC_I);
	localparam int REV_MS = 34;
	localparam int REV_CYC_DEF = REV_MS * 1000000 / CLK_PERIOD_NS;
	localparam int INTERLACE_US_MIN = 1;
	localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;

	// ************************************************************
	// status word bit positions
	// ************************************************************
	localparam int ST_READY = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_REJ_LOST = 2;
	localparam int ST_WCHK = 3;
	localparam int ST_LAST = 4;
	localparam int ST_REL_INT = 5;
	localparam int ST_ADR_INT = 6;
	localparam int ST_RNB_INT = 7;
	localparam int ST_EOP_INT = 8;
	localparam int ST_ABN_INT = 9;
	localparam int ST_RPAR = 10;
	localparam int ST_RSV = 11;
	localparam int STATUS_W = 12;
	localparam logic [11:0] STATUS_RESET = 12'h000;

	// ************************************************************
	// operating modes
	// ************************************************************
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_READ = 2'h1;
	localparam logic [1:0] MODE_WRITE = 2'h2;
	localparam logic [1:0] MODE_WCHK = 2'h3;

	localparam int ADDR_W = 22;
	localparam logic [21:0] ADDR_RESET = 22'h000000;
	localparam logic [6:0] SECTOR_BYTE_ZERO = 7'h00;

endpackage
`default_nettype wire

// File: core/reply_timer.sv
// reply handshake timer for one byte transfer
// assumes data_sig is already synchronised to ref_clk
`timescale 1ns/1ps
`default_nettype none
module reply_timer
	import drum_status_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic data_sig,
	input wire logic wchk,
	output logic reply
);

	typedef enum logic [2:0] {
		RT_IDLE = 3'b001,
		RT_WAIT = 3'b010,
		RT_HOLD = 3'b100
	} rt_state_t;

	rt_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;

	// ************************************************************
	// reply sequence
	// ************************************************************
	// [R21] reply timing
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			RT_IDLE: begin
				if (data_sig) begin
					state_nxt = RT_WAIT;
					cnt_nxt = wchk ? REPLY_WC_CYC : REPLY_RW_CYC;
				end
			end
			RT_WAIT: begin
				// reply rises only after the minimum delay
				if (cnt_r > 4'h1)
					cnt_nxt = cnt_r - 4'h1;
				else if (data_sig) begin
					state_nxt = RT_HOLD;
					cnt_nxt = REPLY_DROP_CYC;
				end else
					state_nxt = RT_IDLE;
			end
			RT_HOLD: begin
				// drop a fixed delay after data drops
				if (!data_sig) begin
					if (cnt_r > 4'h1)
						cnt_nxt = cnt_r - 4'h1;
					else
						state_nxt = RT_IDLE;
				end
			end
			default: state_nxt = RT_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= RT_IDLE;
			cnt_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign reply = (state_r == RT_HOLD);

endmodule // reply_timer
`default_nettype wire

// File: core/drum_status_error_logic.sv
// status word and error handling of the drum controller
// assumes channel pins arrive asynchronously, drum signals likewise
// Operation
// [R1] busy while unit transfers data
// [R2] write busy until last byte; abnormal drops
// [R3] no busy for refused buffers
// [R4] legacy bit 2 is unit reject
// [R5] sector bit 2 is lost data
// [R6] write check error sets, halts if selected
// [R7] last location flag per controller type
// [R8] interrupt cause bits five to nine
// [R9] bit 10 on read or link parity
// [R10] legacy bit 11 reservation reject
// [R11] sector bit 11 other channel only
// [R12] lost data stops transfer, abnormal end
// [R13] toggle parity bit on detected error
// [R14] read parity holds until next operation
// [R15] connect parity error: silent ignore
// [R16] function parity error: flag, ignore
// [R17] data parity error: flag, transfer byte
// [R18] link parity cleared by clear/connect
// [R19] not ready aborts; manual clear only
// [R20] missed byte: readdress, wait revolution
// [R21] reply delay and drop timing
// [R22] bytes spaced by interlace rate
// [R23] 12-bit status word always presented
// [R24] cause bits zero unless selected
// [R25] bit 0 ready of last unit
`timescale 1ns/1ps
`default_nettype none
module drum_status_error_logic
	import drum_status_pkg::*;
#(
	parameter int REV_CYC = REV_CYC_DEF
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic sector_ctl,
	input wire logic full_clear,
	input wire logic manual_clear,
	input wire logic connect_pin,
	input wire logic function_pin,
	input wire logic data_pin,
	input wire logic link_parity_in,
	input wire logic [1:0] mode_sel,
	input wire logic out_buf,
	input wire logic buf_start,
	input wire logic buf_end,
	input wire logic [6:0] start_byte,
	input wire logic drum_ready,
	input wire logic unit_rej,
	input wire logic other_rsv,
	input wire logic last_addr_used,
	input wire logic wrap_attempt,
	input wire logic last_byte_on_drum,
	input wire logic miscompare,
	input wire logic read_par_err,
	input wire logic drum_link_par_err,
	input wire logic addr_match,
	input wire logic other_release,
	input wire logic [4:0] int_sel,
	input wire logic [7:0] interlace_us,
	input wire logic [12:0] byte_in,
	output logic [12:0] byte_out,
	output logic [11:0] status,
	output logic reply,
	output logic link_parity_err,
	output logic link_parity_lamp,
	output logic connected,
	output logic readdress,
	output logic addr_decr,
	output logic transfer_stop
);

	// ************************************************************
	// input synchronisers
	// ************************************************************
	localparam int NSYNC = 24;
	logic [NSYNC-1:0] s1_r, s2_r;
	wire logic [NSYNC-1:0] raw = {connect_pin, function_pin, data_pin,
		link_parity_in, drum_ready, unit_rej, other_rsv, last_addr_used,
		wrap_attempt, last_byte_on_drum, miscompare, read_par_err,
		drum_link_par_err, addr_match, other_release, int_sel,
		buf_start, buf_end, manual_clear, full_clear};

	// only the second stage is read by logic
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
		end
	end

	logic c_con, c_fn, c_dat, c_lp, c_rdy, c_urej, c_orsv, c_lau, c_wrap;
	logic c_lbd, c_mis, c_rpe, c_dlpe, c_amt, c_orel, c_bs, c_be, c_mclr;
	logic c_fclr;
	logic [4:0] c_isel;
	assign {c_con, c_fn, c_dat, c_lp, c_rdy, c_urej, c_orsv, c_lau, c_wrap,
		c_lbd, c_mis, c_rpe, c_dlpe, c_amt, c_orel, c_isel, c_bs, c_be,
		c_mclr, c_fclr} = s2_r;

	logic con_d_r, fn_d_r, dat_d_r;
	wire logic con_rise = c_con & ~con_d_r;
	wire logic fn_rise = c_fn & ~fn_d_r;
	wire logic dat_rise = c_dat & ~dat_d_r;
	wire logic clr = c_fclr | c_mclr;

	// ************************************************************
	// operation state machine
	// ************************************************************
	typedef enum logic [3:0] {
		OP_IDLE = 4'b0001,
		OP_XFER = 4'b0010,
		OP_WTAIL = 4'b0100,
		OP_READDR = 4'b1000
	} op_state_t;

	op_state_t op_r, op_nxt;
	logic [31:0] tmr_r, tmr_nxt;
	logic busy_r, busy_nxt, abn_r, abn_nxt, eop_r, eop_nxt;
	logic stop_r, stop_nxt, rdr_r, rdr_nxt, dec_r, dec_nxt;
	logic [1:0] mode_r, mode_nxt;

	// buffer is refused on not ready, wrong direction or no mode
	function automatic logic buf_ok(input logic [1:0] m, input logic o,
		input logic rdy);
		buf_ok = rdy && (m != MODE_NONE) && ((m == MODE_WRITE) == o);
	endfunction

	// abnormal end sources that stop at once, soft errors only when int_sel bit 4 is set
	wire logic lost = sector_ctl &&
		((op_r == OP_XFER && tmr_r == 32'h0) ||
		(c_bs && start_byte != SECTOR_BYTE_ZERO));
	wire logic notrdy = ~c_rdy & (op_r != OP_IDLE);
	wire logic soft_err = c_mis | c_rpe | (sector_ctl & c_dlpe);
	wire logic hard_abn = notrdy | lost | (c_lau & ~sector_ctl) | c_wrap;
	wire logic [31:0] slot = 32'(interlace_us) * 32'(CYC_PER_US);

	always_comb begin
		op_nxt = op_r;
		tmr_nxt = tmr_r;
		busy_nxt = busy_r;
		abn_nxt = 1'b0;
		eop_nxt = 1'b0;
		stop_nxt = stop_r;
		rdr_nxt = 1'b0;
		dec_nxt = 1'b0;
		case (op_r)
			OP_IDLE: begin
				// [R3] refused buffers
				if (c_bs && buf_ok(mode_r, out_buf, c_rdy)) begin
					op_nxt = OP_XFER;
					// [R1] busy raised
					busy_nxt = 1'b1;
					stop_nxt = 1'b0;
					tmr_nxt = slot;
				end
			end
			OP_XFER: begin
				// [R22] byte window
				if (dat_rise)
					tmr_nxt = slot;
				else if (tmr_r != 32'h0)
					tmr_nxt = tmr_r - 32'h1;
				// [R12] lost data abort
				// [R19] not ready abort
				if (hard_abn || (soft_err && c_isel[4])) begin
					op_nxt = OP_IDLE;
					// [R2] abnormal drops busy
					busy_nxt = 1'b0;
					abn_nxt = 1'b1;
					eop_nxt = 1'b1;
					stop_nxt = 1'b1;
				end else if (tmr_r == 32'h0 && !sector_ctl) begin
					// [R20] missed byte
					op_nxt = OP_READDR;
					dec_nxt = 1'b1;
					tmr_nxt = 32'(REV_CYC);
				end else if (c_be) begin
					// [R2] write tail
					op_nxt = (mode_r == MODE_WRITE) ? OP_WTAIL : OP_IDLE;
					busy_nxt = (mode_r == MODE_WRITE);
					eop_nxt = (mode_r != MODE_WRITE);
				end
			end
			OP_WTAIL: begin
				if (notrdy) begin
					op_nxt = OP_IDLE;
					busy_nxt = 1'b0;
					abn_nxt = 1'b1;
					eop_nxt = 1'b1;
				end else if (c_lbd) begin
					op_nxt = OP_IDLE;
					busy_nxt = 1'b0;
					eop_nxt = 1'b1;
				end
			end
			OP_READDR: begin
				// [R20] one revolution
				rdr_nxt = 1'b1;
				if (tmr_r != 32'h0)
					tmr_nxt = tmr_r - 32'h1;
				else begin
					op_nxt = OP_XFER;
					tmr_nxt = slot;
				end
			end
			default: op_nxt = OP_IDLE;
		endcase
		if (clr) begin
			op_nxt = OP_IDLE;
			busy_nxt = 1'b0;
		end
	end

	// ************************************************************
	// error flags and interrupt causes
	// ************************************************************
	logic wchk_r, wchk_nxt, rpar_r, rpar_nxt, last_r, last_nxt;
	logic lost_r, lost_nxt, lpe_r, lpe_nxt, lamp_r, lamp_nxt;
	logic con_r, con_nxt, rej_r, rej_nxt, rsv_r, rsv_nxt, nr_r, nr_nxt;
	logic [4:0] cause_r, cause_nxt;
	wire logic op_start = (op_r == OP_IDLE) && (op_nxt == OP_XFER);
	wire logic lp_bad = c_lp;

	always_comb begin
		// [R6] [R14] cleared at start, set wins later
		wchk_nxt = op_start ? 1'b0 : wchk_r;
		rpar_nxt = op_start ? 1'b0 : rpar_r;
		lost_nxt = op_start ? 1'b0 : lost_r;
		// [R6] miscompare
		if (c_mis && mode_r == MODE_WCHK && op_r != OP_IDLE)
			wchk_nxt = 1'b1;
		// [R9] read or link parity
		if ((c_rpe || (sector_ctl && c_dlpe)) && op_r != OP_IDLE)
			rpar_nxt = 1'b1;
		// [R5] lost data
		if (lost)
			lost_nxt = 1'b1;
		// [R7] last location flag
		last_nxt = last_r;
		if (con_rise || clr)
			last_nxt = 1'b0;
		if ((~sector_ctl & c_lau) | (sector_ctl & c_wrap))
			last_nxt = 1'b1;
		// [R15] connect with parity error
		con_nxt = con_r;
		rej_nxt = rej_r;
		rsv_nxt = rsv_r;
		lpe_nxt = lpe_r;
		lamp_nxt = lamp_r;
		if (con_rise) begin
			// [R18] new connect clears on sector type
			if (sector_ctl)
				lpe_nxt = 1'b0;
			if (lp_bad) begin
				con_nxt = 1'b0;
				lamp_nxt = 1'b1;
			end else begin
				con_nxt = ~(c_urej | c_orsv);
				// [R4] unit reject
				rej_nxt = ~sector_ctl & c_urej;
				// [R10] [R11] reservation reject
				rsv_nxt = sector_ctl ? c_orsv : (c_orsv | c_urej & c_orsv);
			end
		end
		// [R16] function parity error
		if (fn_rise && lp_bad && con_r) begin
			lpe_nxt = 1'b1;
			lamp_nxt = 1'b1;
		end
		// [R16] mode taken only from a clean function code
		mode_nxt = mode_r;
		if (fn_rise && !lp_bad && con_r)
			mode_nxt = mode_sel;
		// [R17] data parity error
		if (dat_rise && lp_bad && con_r) begin
			lpe_nxt = 1'b1;
			lamp_nxt = 1'b1;
		end
		// [R18] clearing
		if (c_fclr || c_mclr) begin
			mode_nxt = MODE_NONE;
			lpe_nxt = 1'b0;
			lamp_nxt = 1'b0;
			con_nxt = 1'b0;
		end
		// [R19] not ready held until manual clear
		// only a drop during an operation latches, so reset is not a fault
		nr_nxt = c_mclr ? 1'b0 : (nr_r | notrdy);
		// [R8] [R24] causes gated by selection
		cause_nxt = cause_r & c_isel;
		if (c_orel && c_isel[0])
			cause_nxt[0] = 1'b1;
		if (c_amt && c_isel[1])
			cause_nxt[1] = 1'b1;
		if (c_rdy && !busy_r && busy_nxt == 1'b0 && eop_r && c_isel[2])
			cause_nxt[2] = 1'b1;
		if (eop_r && c_isel[3])
			cause_nxt[3] = 1'b1;
		if (abn_r && c_isel[4])
			cause_nxt[4] = 1'b1;
		if (clr)
			cause_nxt = 5'h00;
	end

	// ************************************************************
	// status word and data path
	// ************************************************************
	logic [11:0] st_nxt;
	logic [12:0] bo_nxt;

	always_comb begin
		// [R23] [R25] status word
		st_nxt = STATUS_RESET;
		st_nxt[ST_READY] = c_rdy & ~nr_r;
		st_nxt[ST_BUSY] = busy_r;
		// [R4] [R5] shared bit
		st_nxt[ST_REJ_LOST] = sector_ctl ? lost_r : rej_r;
		st_nxt[ST_WCHK] = wchk_r;
		st_nxt[ST_LAST] = last_r;
		st_nxt[ST_ABN_INT:ST_REL_INT] = cause_r;
		st_nxt[ST_RPAR] = rpar_r;
		st_nxt[ST_RSV] = rsv_r;
		// [R13] toggle parity bit on error
		bo_nxt = byte_in;
		if (c_lp || c_rpe || c_dlpe)
			bo_nxt[12] = ~byte_in[12];
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			op_r <= OP_IDLE;
			tmr_r <= 32'h0;
			busy_r <= 1'b0;
			abn_r <= 1'b0;
			eop_r <= 1'b0;
			stop_r <= 1'b0;
			rdr_r <= 1'b0;
			dec_r <= 1'b0;
			wchk_r <= 1'b0;
			rpar_r <= 1'b0;
			last_r <= 1'b0;
			lost_r <= 1'b0;
			lpe_r <= 1'b0;
			lamp_r <= 1'b0;
			con_r <= 1'b0;
			rej_r <= 1'b0;
			rsv_r <= 1'b0;
			nr_r <= 1'b0;
			mode_r <= MODE_NONE;
			cause_r <= 5'h00;
			status <= STATUS_RESET;
			byte_out <= 13'h0000;
			con_d_r <= 1'b0;
			fn_d_r <= 1'b0;
			dat_d_r <= 1'b0;
		end else begin
			op_r <= op_nxt;
			tmr_r <= tmr_nxt;
			busy_r <= busy_nxt;
			abn_r <= abn_nxt;
			eop_r <= eop_nxt;
			stop_r <= stop_nxt;
			rdr_r <= rdr_nxt;
			dec_r <= dec_nxt;
			wchk_r <= wchk_nxt;
			rpar_r <= rpar_nxt;
			last_r <= last_nxt;
			lost_r <= lost_nxt;
			lpe_r <= lpe_nxt;
			lamp_r <= lamp_nxt;
			con_r <= con_nxt;
			rej_r <= rej_nxt;
			rsv_r <= rsv_nxt;
			nr_r <= nr_nxt;
			mode_r <= mode_nxt;
			cause_r <= cause_nxt;
			status <= st_nxt;
			byte_out <= bo_nxt;
			con_d_r <= c_con;
			fn_d_r <= c_fn;
			dat_d_r <= c_dat;
		end
	end

	// ************************************************************
	// reply handshake
	// ************************************************************
	logic reply_c, reply_r;
	reply_timer u_reply (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.data_sig(c_dat & con_r),
		.wchk(mode_r == MODE_WCHK),
		.reply(reply_c)
	);

	// output flops keep every port registered
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reply_r <= 1'b0;
			link_parity_err <= 1'b0;
			link_parity_lamp <= 1'b0;
			connected <= 1'b0;
			readdress <= 1'b0;
			addr_decr <= 1'b0;
			transfer_stop <= 1'b0;
		end else begin
			reply_r <= reply_c;
			link_parity_err <= lpe_r;
			link_parity_lamp <= lamp_r;
			connected <= con_r;
			readdress <= rdr_r;
			addr_decr <= dec_r;
			transfer_stop <= stop_r;
		end
	end
	assign reply = reply_r;

	// ************************************************************
	// checks
	// ************************************************************
	AST_BUSY_ABN_DROP: assert property ( // R2
		@(posedge ref_clk) disable iff (!rstn) abn_r |-> !busy_r)
		else $error("busy held after abnormal end");
	AST_RPAR_STATUS: assert property ( // R9
		@(posedge ref_clk) disable iff (!rstn) rpar_r |=> status[ST_RPAR])
		else $error("bit 10 missing");
	// status shows causes two cycles after the selection that gates them
	AST_CAUSE_SEL: assert property ( // R24
		@(posedge ref_clk) disable iff (!rstn)
		(status[ST_ABN_INT:ST_REL_INT] & ~$past(c_isel, 2)) == 5'h00)
		else $error("cause unselected");
	AST_BUSY_STATUS: assert property ( // R1
		@(posedge ref_clk) disable iff (!rstn) busy_r |=> status[ST_BUSY])
		else $error("busy not shown");
	AST_READDR_DEC: assert property ( // R20
		@(posedge ref_clk) disable iff (!rstn)
		(op_r == OP_XFER && op_nxt == OP_READDR) |=> dec_r ##1 addr_decr)
		else $error("no address decrement");
	AST_LOST_STOP: assert property ( // R12
		@(posedge ref_clk) disable iff (!rstn)
		(lost && op_r == OP_XFER && !clr) |=> op_r == OP_IDLE && abn_r)
		else $error("lost data did not abort");
	AST_CON_PE: assert property ( // R15
		@(posedge ref_clk) disable iff (!rstn)
		(con_rise && lp_bad && !clr) |=> !con_r && lamp_r)
		else $error("bad connect taken");
	AST_DATA_PE: assert property ( // R17
		@(posedge ref_clk) disable iff (!rstn)
		(dat_rise && lp_bad && con_r && !clr) |=> lpe_r ##1 link_parity_err)
		else $error("data parity not flagged");

endmodule // drum_status_error_logic
`default_nettype wire

// File: verification/chan_model.sv
// data channel model: connect, function, buffer and byte transfer tasks
// assumes the tasks are called one at a time from the bench
`timescale 1ns/1ps
`default_nettype none
module chan_model
	import drum_status_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reply,
	input wire logic [12:0] byte_out,
	output logic connect_pin,
	output logic function_pin,
	output logic data_pin,
	output logic link_parity_in,
	output logic [1:0] mode_sel,
	output logic out_buf,
	output logic buf_start,
	output logic buf_end,
	output logic [12:0] byte_in
);
	// ************************************************************
	// channel side drivers
	// ************************************************************
	// all pins idle at time zero
	initial begin
		{connect_pin, function_pin, data_pin, link_parity_in} = 4'h0;
		{mode_sel, out_buf, buf_start, buf_end} = 5'h00;
		byte_in = 13'h0000;
	end
	// connect is a level held while connected
	task automatic conn(input logic on, input logic par);
		@(posedge ref_clk);
		connect_pin <= on;
		link_parity_in <= par;
		repeat (4) @(posedge ref_clk);
		link_parity_in <= 1'b0;
	endtask
	// mode and direction ride with the function strobe
	task automatic func(input logic [1:0] m, input logic ob, input logic par);
		@(posedge ref_clk);
		mode_sel <= m;
		out_buf <= ob;
		function_pin <= 1'b1;
		link_parity_in <= par;
		repeat (4) @(posedge ref_clk);
		function_pin <= 1'b0;
		link_parity_in <= 1'b0;
	endtask
	// buffer start or end, held a few cycles for the synchroniser
	task automatic bufp(input logic ends);
		@(posedge ref_clk);
		if (ends) buf_end <= 1'b1;
		else buf_start <= 1'b1;
		repeat (4) @(posedge ref_clk);
		{buf_start, buf_end} <= 2'h0;
	endtask
	task automatic xfer(input logic [12:0] b, input logic par, output int lat,
		output logic [12:0] got, output logic ok);
		int n;
		@(posedge ref_clk);
		byte_in <= b;
		link_parity_in <= par;
		data_pin <= 1'b1;
		n = 0;
		// reply seen at a falling edge is sampled high at the next rising one
		do begin
			@(negedge ref_clk);
			n++;
		end while (reply !== 1'b1 && n < 40);
		lat = n;
		got = byte_out;
		ok = (reply === 1'b1);
		@(posedge ref_clk);
		data_pin <= 1'b0;
		link_parity_in <= 1'b0;
		byte_in <= ~b; // released data no longer holds the old value
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (reply !== 1'b0 && n < 20);
		ok = ok && (reply === 1'b0);
	endtask
endmodule // chan_model
`default_nettype wire

// File: verification/test_drum_status_error_logic.sv
// bench for the drum status and error logic, legacy controller setting plus one sector test
// assumes the channel model drives every channel pin
`timescale 1ns/1ps
`default_nettype none
module test_drum_status_error_logic;
	import drum_status_pkg::*;
	logic ref_clk = 1'b0, rstn = 1'b0, sector_ctl = 1'b0, full_clear = 1'b0;
	logic manual_clear = 1'b0, drum_ready = 1'b1, unit_rej = 1'b0;
	logic other_rsv = 1'b0, last_addr_used = 1'b0, wrap_attempt = 1'b0;
	logic last_byte_on_drum = 1'b0, miscompare = 1'b0, read_par_err = 1'b0;
	logic drum_link_par_err = 1'b0, addr_match = 1'b0, other_release = 1'b0;
	logic [6:0] start_byte = 7'h00;
	logic [4:0] int_sel = 5'h00;
	logic [7:0] interlace_us = 8'hFF;
	logic connect_pin, function_pin, data_pin, link_parity_in, out_buf;
	logic buf_start, buf_end, reply, link_parity_err, link_parity_lamp;
	logic connected, readdress, addr_decr, transfer_stop, ok;
	logic [1:0] mode_sel;
	logic [12:0] byte_in, byte_out, got;
	logic [11:0] status;
	int miscompares = 0, num_checks = 0, lat, n;

	always #50 ref_clk = ~ref_clk;

	drum_status_error_logic #(.REV_CYC(50)) drum_status_error_logic_i (
		.ref_clk, .rstn, .sector_ctl, .full_clear, .manual_clear, .connect_pin,
		.function_pin, .data_pin, .link_parity_in, .mode_sel, .out_buf,
		.buf_start, .buf_end, .start_byte, .drum_ready, .unit_rej, .other_rsv,
		.last_addr_used, .wrap_attempt, .last_byte_on_drum, .miscompare,
		.read_par_err, .drum_link_par_err, .addr_match, .other_release,
		.int_sel, .interlace_us, .byte_in, .byte_out, .status, .reply,
		.link_parity_err, .link_parity_lamp, .connected, .readdress,
		.addr_decr, .transfer_stop);
	chan_model chan_model_i (.ref_clk, .reply, .byte_out, .connect_pin,
		.function_pin, .data_pin, .link_parity_in, .mode_sel, .out_buf,
		.buf_start, .buf_end, .byte_in);

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic ck(input string what, input logic [12:0] exp,
		input logic [12:0] seen);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// status lags its cause by two synchroniser stages and up to three registers
	task automatic settle();
		repeat (6) @(negedge ref_clk);
	endtask
	task automatic clr(input logic manual);
		@(posedge ref_clk);
		if (manual) manual_clear <= 1'b1;
		else full_clear <= 1'b1;
		repeat (4) @(posedge ref_clk);
		{manual_clear, full_clear} <= 2'h0;
		settle();
	endtask
	task automatic reconn();
		chan_model_i.conn(1'b0, 1'b0);
		chan_model_i.conn(1'b1, 1'b0);
		settle();
	endtask
	task automatic tend(input string s);
		$display("end of test %s", s);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// hang guard, well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		$display("MISMATCH watchdog expected end seen hang");
		wrap_up();
	end

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		settle();
		ck("status", 13'h001, status);
		ck("reply", 1'b0, reply);
		tend("reset");
		chan_model_i.conn(1'b1, 1'b1);
		settle();
		ck("connected", 1'b0, connected);
		ck("lamp", 1'b1, link_parity_lamp);
		ck("perr", 1'b0, link_parity_err);
		reconn();
		ck("connected", 1'b1, connected);
		ck("lamp", 1'b1, link_parity_lamp);
		clr(1'b0);
		ck("lamp", 1'b0, link_parity_lamp);
		reconn();
		ck("ready", 1'b1, status[ST_READY]);
		tend("connect");
		chan_model_i.func(MODE_READ, 1'b0, 1'b1);
		chan_model_i.bufp(1'b0);
		settle();
		ck("perr", 1'b1, link_parity_err);
		ck("busy", 1'b0, status[ST_BUSY]);
		clr(1'b0);
		reconn();
		chan_model_i.func(MODE_READ, 1'b1, 1'b0);
		chan_model_i.bufp(1'b0);
		settle();
		ck("busy", 1'b0, status[ST_BUSY]);
		tend("refused");
		int_sel <= 5'h0F;
		chan_model_i.func(MODE_READ, 1'b0, 1'b0);
		chan_model_i.bufp(1'b0);
		settle();
		ck("busy", 1'b1, status[ST_BUSY]);
		read_par_err <= 1'b1;
		chan_model_i.xfer(13'h1ABC, 1'b1, lat, got, ok);
		read_par_err <= 1'b0;
		ck("reply", 1'b1, ok);
		ck("reply_gap", 1'b1, lat > REPLY_RW_CYC);
		ck("byte", 13'h0ABC, got);
		settle();
		ck("perr", 1'b1, link_parity_err);
		ck("rpar", 1'b1, status[ST_RPAR]);
		chan_model_i.xfer(13'h0123, 1'b0, lat, got, ok);
		ck("byte", 13'h0123, got);
		ck("rpar", 1'b1, status[ST_RPAR]);
		chan_model_i.bufp(1'b1);
		settle();
		ck("busy", 1'b0, status[ST_BUSY]);
		ck("eop", 1'b1, status[ST_EOP_INT]);
		ck("rnb", 1'b1, status[ST_RNB_INT]);
		ck("abn", 1'b0, status[ST_ABN_INT]);
		tend("read");
		int_sel <= 5'h10;
		chan_model_i.func(MODE_WCHK, 1'b0, 1'b0);
		chan_model_i.bufp(1'b0);
		miscompare <= 1'b1;
		chan_model_i.xfer(13'h0555, 1'b0, lat, got, ok);
		miscompare <= 1'b0;
		ck("reply_gap", 1'b1, lat > REPLY_WC_CYC);
		settle();
		ck("wchk", 1'b1, status[ST_WCHK]);
		ck("busy", 1'b0, status[ST_BUSY]);
		ck("stop", 1'b1, transfer_stop);
		ck("abn", 1'b1, status[ST_ABN_INT]);
		ck("eop", 1'b0, status[ST_EOP_INT]);
		tend("write check");
		int_sel <= 5'h00;
		chan_model_i.func(MODE_WRITE, 1'b1, 1'b0);
		chan_model_i.bufp(1'b0);
		chan_model_i.xfer(13'h1000, 1'b0, lat, got, ok);
		chan_model_i.bufp(1'b1);
		settle();
		ck("busy", 1'b1, status[ST_BUSY]);
		ck("wchk", 1'b0, status[ST_WCHK]);
		last_byte_on_drum <= 1'b1;
		settle();
		last_byte_on_drum <= 1'b0;
		ck("busy", 1'b0, status[ST_BUSY]);
		tend("write");
		int_sel <= 5'h18;
		chan_model_i.func(MODE_WRITE, 1'b1, 1'b0);
		chan_model_i.bufp(1'b0);
		settle();
		drum_ready <= 1'b0;
		settle();
		ck("busy", 1'b0, status[ST_BUSY]);
		ck("abn", 1'b1, status[ST_ABN_INT]);
		ck("eop", 1'b1, status[ST_EOP_INT]);
		drum_ready <= 1'b1;
		settle();
		ck("ready", 1'b0, status[ST_READY]);
		clr(1'b1);
		reconn();
		ck("ready", 1'b1, status[ST_READY]);
		tend("not ready");
		unit_rej <= 1'b1;
		other_rsv <= 1'b1;
		reconn();
		ck("reject", 1'b1, status[ST_REJ_LOST]);
		ck("rsv", 1'b1, status[ST_RSV]);
		{unit_rej, other_rsv} <= 2'h0;
		reconn();
		tend("reject");
		int_sel <= 5'h03;
		{other_release, addr_match, last_addr_used} <= 3'h7;
		settle();
		{other_release, addr_match, last_addr_used} <= 3'h0;
		settle();
		ck("rel", 1'b1, status[ST_REL_INT]);
		ck("adr", 1'b1, status[ST_ADR_INT]);
		ck("last", 1'b1, status[ST_LAST]);
		clr(1'b0);
		ck("last", 1'b0, status[ST_LAST]);
		ck("adr", 1'b0, status[ST_ADR_INT]);
		reconn();
		tend("causes");
		// sector controller: nonzero start byte, wrap and drum link error
		sector_ctl <= 1'b1;
		{start_byte, wrap_attempt, drum_link_par_err} <= {7'h05, 2'h3};
		chan_model_i.func(MODE_READ, 1'b0, 1'b0);
		chan_model_i.bufp(1'b0);
		settle();
		ck("lost", 1'b1, status[ST_REJ_LOST]);
		ck("busy", 1'b0, status[ST_BUSY]);
		ck("rpar", 1'b1, status[ST_RPAR]);
		ck("last", 1'b1, status[ST_LAST]);
		{sector_ctl, start_byte, wrap_attempt, drum_link_par_err} <= 10'h000;
		tend("sector");
		interlace_us <= 8'h01;
		chan_model_i.func(MODE_READ, 1'b0, 1'b0);
		chan_model_i.bufp(1'b0);
		n = 0;
		ok = 1'b0;
		// missed byte window is one microsecond, give it ample time
		while (readdress !== 1'b1 && n < 300) begin
			@(negedge ref_clk);
			ok = ok | (addr_decr === 1'b1);
			n++;
		end
		ck("readdress", 1'b1, readdress);
		ck("decr", 1'b1, ok);
		tend("readdress");
		wrap_up();
	end
endmodule // test_drum_status_error_logic
`default_nettype wire
